/* hdl/vpi_forward.sv */
`default_nettype none
module vpi_forward #(
   parameter int PORTS = vpi_pkg::NUM_PORTS,
   parameter int ENTRIES = vpi_pkg::NUM_ENTRIES
) (
   input wire logic i_clock,                                    // Core clock, 125 MHz.
   input wire logic i_reset,                                    // Synchronous reset.
   input wire logic i_frame_valid,                              // Frame header present.
   input wire logic [$clog2(PORTS)-1:0] i_frame_port,           // Ingress port number.
   input wire logic [vpi_pkg::TPID_W-1:0] i_frame_tpid,         // EtherType after source.
   input wire logic [vpi_pkg::VID_W-1:0] i_frame_vid,           // VLAN ID field if tagged.
   input wire logic i_isolation_wr,                             // Load isolation mask.
   input wire logic [PORTS-1:0] i_isolation_mask,               // Isolated port bits.
   input wire logic i_pvlan_wr,                                 // Load private VLAN mask.
   input wire logic [PORTS-1:0] i_pvlan_mask,                   // Private VLAN members.
   input wire logic i_aware_wr,                                 // Load VLAN aware mask.
   input wire logic [PORTS-1:0] i_aware_mask,                   // VLAN aware ports.
   input wire logic [PORTS-1:0] i_custom_sport_mask,            // Custom service ports.
   input wire logic i_stag_wr,                                  // Load service EtherType.
   input wire logic [vpi_pkg::TPID_W-1:0] i_stag_value,         // New service EtherType.
   input wire logic i_port_default_vlan_id_wr,                                  // Load one default VID.
   input wire logic [$clog2(PORTS)-1:0] i_port_default_vlan_id_port,            // Port to update.
   input wire logic [vpi_pkg::VID_W-1:0] i_port_default_vlan_id_value,          // New default VID.
   input wire logic i_vlan_wr,                                  // Write VLAN table row.
   input wire logic [$clog2(ENTRIES)-1:0] i_vlan_index,         // Row number.
   input wire logic [vpi_pkg::VID_W-1:0] i_vlan_vid,            // Row VLAN ID.
   input wire logic [PORTS-1:0] i_vlan_member,                  // Row member ports.
   input wire logic [PORTS-1:0] i_vlan_untag,                   // Row untagged members.
   output logic o_fwd_valid,                                    // Result pulse.
   output logic [$clog2(PORTS)-1:0] o_fwd_port,                 // Ingress port of result.
   output logic [vpi_pkg::VID_W-1:0] o_fwd_vid,                 // Classified VLAN ID.
   output logic [PORTS-1:0] o_fwd_mask,                         // Egress ports.
   output logic [PORTS-1:0] o_fwd_untag_mask,                   // Egress ports, tag stripped.
   output logic [PORTS-1:0] o_fwd_tag_mask,                     // Egress ports, tag added.
   output logic o_fwd_inner_kept,                               // Received tag left in frame.
   output logic o_fwd_src_isolated,                             // Ingress port isolated.
   output logic o_fwd_drop,                                     // Frame not forwarded.
   output logic [PORTS-1:0] o_isolation_mask,                   // Current isolation bits.
   output logic [vpi_pkg::TPID_W-1:0] o_stag_tpid               // Current service EtherType.
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [PORTS-1:0] iso_q;
   logic [PORTS-1:0] pvlan_q;
   logic [PORTS-1:0] aware_q;
   logic [vpi_pkg::TPID_W-1:0] stag_q;
   logic [vpi_pkg::VID_W-1:0] port_default_vlan_id_q [PORTS];

   // One bit per port, shared by every private VLAN the port is in.
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         iso_q <= {PORTS{vpi_pkg::ISOLATION_RESET}};
      end else if (i_isolation_wr) begin
         iso_q <= i_isolation_mask;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pvlan_q <= {PORTS{vpi_pkg::PVLAN_MEMBER_RESET}};
      end else if (i_pvlan_wr) begin
         pvlan_q <= i_pvlan_mask;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         aware_q <= {PORTS{vpi_pkg::AWARE_RESET}};
      end else if (i_aware_wr) begin
         aware_q <= i_aware_mask;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         stag_q <= vpi_pkg::STAG_TPID_RESET;
      end else if (i_stag_wr) begin
         stag_q <= i_stag_value;
      end
   end

   always_ff @(posedge i_clock) begin
      for (int p = 0; p < PORTS; p++) begin
         if (i_reset) begin
            port_default_vlan_id_q[p] <= vpi_pkg::DEFAULT_VID;
         end else if (i_port_default_vlan_id_wr && i_port_default_vlan_id_port == ($clog2(PORTS))'(p)) begin
            port_default_vlan_id_q[p] <= i_port_default_vlan_id_value;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic tag_seen;
   logic port_aware;
   logic [vpi_pkg::VID_W-1:0] ingress_port_default_vlan_id;
   logic s1_valid_q;
   logic [$clog2(PORTS)-1:0] s1_port_q;
   logic [vpi_pkg::VID_W-1:0] s1_vid_q;
   logic s1_inner_q;

   // Custom service ports also take the configurable service EtherType as a tag.
   assign tag_seen = (i_frame_tpid == vpi_pkg::CTAG_TPID) ||
                     (i_custom_sport_mask[i_frame_port] && i_frame_tpid == stag_q);
   assign port_aware = aware_q[i_frame_port];
   assign ingress_port_default_vlan_id = port_default_vlan_id_q[i_frame_port];

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         s1_valid_q <= 1'b0;
         s1_port_q <= '0;
         s1_vid_q <= vpi_pkg::DEFAULT_VID;
         s1_inner_q <= 1'b0;
      end else begin
         s1_valid_q <= i_frame_valid;
         s1_port_q <= i_frame_port;
         // Tag on an aware port wins; otherwise the port default is used.
         s1_vid_q <= (port_aware && tag_seen) ? i_frame_vid : ingress_port_default_vlan_id;
         s1_inner_q <= !port_aware && tag_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   vpi_tbl_if #(.PORTS(PORTS), .ENTRIES(ENTRIES)) tbl ();

   assign tbl.lookup_vid = s1_vid_q;
   assign tbl.wr_en = i_vlan_wr;
   assign tbl.wr_index = i_vlan_index;
   assign tbl.wr_vid = i_vlan_vid;
   assign tbl.wr_member = i_vlan_member;
   assign tbl.wr_untag = i_vlan_untag;

   for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
      vpi_vlan_entry #(.INDEX(e), .PORTS(PORTS), .ENTRIES(ENTRIES)) u_entry (
         .i_clock(i_clock),
         .i_reset(i_reset),
         .tbl(tbl.table_side)
      );
   end

   logic lk_hit;
   logic [PORTS-1:0] lk_member;
   logic [PORTS-1:0] lk_untag;

   // Lowest matching row wins when software loads a VLAN ID twice.
   always_comb begin
      lk_hit = 1'b0;
      lk_member = '0;
      lk_untag = '0;
      for (int e = ENTRIES - 1; e >= 0; e--) begin
         if (tbl.hit[e]) begin
            lk_hit = 1'b1;
            lk_member = tbl.member[e];
            lk_untag = tbl.untag[e];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [PORTS-1:0] src_bit;
   logic src_iso;
   logic [PORTS-1:0] iso_allow;
   logic [PORTS-1:0] egress;
   logic drop;

   assign src_bit = PORTS'(1) << s1_port_q;
   assign src_iso = iso_q[s1_port_q];
   // Isolated ingress reaches only promiscuous private VLAN members.
   assign iso_allow = src_iso ? (pvlan_q & ~iso_q) : {PORTS{1'b1}};
   assign drop = !lk_hit || !pvlan_q[s1_port_q];
   assign egress = drop ? '0 : (lk_member & pvlan_q & iso_allow & ~src_bit);

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_fwd_valid <= 1'b0;
         o_fwd_port <= '0;
         o_fwd_vid <= vpi_pkg::DEFAULT_VID;
         o_fwd_mask <= '0;
         o_fwd_untag_mask <= '0;
         o_fwd_tag_mask <= '0;
         o_fwd_inner_kept <= 1'b0;
         o_fwd_src_isolated <= 1'b0;
         o_fwd_drop <= 1'b0;
      end else begin
         o_fwd_valid <= s1_valid_q;
         o_fwd_port <= s1_port_q;
         o_fwd_vid <= s1_vid_q;
         o_fwd_mask <= egress;
         o_fwd_untag_mask <= egress & lk_untag;
         o_fwd_tag_mask <= egress & ~lk_untag;
         o_fwd_inner_kept <= s1_inner_q;
         o_fwd_src_isolated <= src_iso;
         o_fwd_drop <= drop;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_isolation_mask <= {PORTS{vpi_pkg::ISOLATION_RESET}};
         o_stag_tpid <= vpi_pkg::STAG_TPID_RESET;
      end else begin
         o_isolation_mask <= iso_q;
         o_stag_tpid <= stag_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   chk_ingress_bit_clear: assert property (
      o_fwd_valid |-> !o_fwd_mask[o_fwd_port])
      else $error("Ingress port present in egress mask.");
   chk_isolated_to_promisc: assert property (
      o_fwd_valid && o_fwd_src_isolated |-> (o_fwd_mask & $past(iso_q)) == '0)
      else $error("Isolated ingress reached an isolated port.");
   chk_member_only: assert property (
      o_fwd_valid |-> (o_fwd_mask & ~$past(lk_member)) == '0)
      else $error("Frame sent to a non-member port.");
   chk_promisc_full_mask: assert property (
      o_fwd_valid && !o_fwd_src_isolated && !o_fwd_drop
      |-> o_fwd_mask == ($past(lk_member) & $past(pvlan_q) & ~(PORTS'(1) << o_fwd_port)))
      else $error("Promiscuous ingress mask differs from VLAN mask.");
   chk_untagged_port_default_vlan_id: assert property (
      i_frame_valid && !(port_aware && tag_seen) |=> s1_vid_q == $past(ingress_port_default_vlan_id))
      else $error("Frame not classified to port default VLAN ID.");
   chk_tagged_vid: assert property (
      i_frame_valid && port_aware && tag_seen |=> ##1 o_fwd_vid == $past(i_frame_vid, 2))
      else $error("Tagged frame not classified to its tag.");
   chk_strip_untag: assert property (
      o_fwd_valid |-> (o_fwd_untag_mask | o_fwd_tag_mask) == o_fwd_mask
                      && (o_fwd_untag_mask & o_fwd_tag_mask) == '0)
      else $error("Egress tag handling does not cover the mask.");
   chk_pvlan_member: assert property (
      s1_valid_q && !pvlan_q[s1_port_q] |=> o_fwd_drop && o_fwd_mask == '0)
      else $error("Port outside private VLAN forwarded a frame.");
   chk_iso_reset: assert property (@(posedge i_clock) disable iff (1'b0)
      $past(i_reset) |-> iso_q == '0 && stag_q == vpi_pkg::STAG_TPID_RESET)
      else $error("Isolation or service EtherType not at reset value.");
   chk_iso_write: assert property (
      i_isolation_wr |=> iso_q == $past(i_isolation_mask))
      else $error("Isolation write not taken.");

   cov_isolated_frame: cover property (o_fwd_valid && o_fwd_src_isolated && o_fwd_mask != '0);
   cov_tag_strip: cover property (o_fwd_valid && o_fwd_untag_mask != '0 && o_fwd_tag_mask != '0);
   cov_drop: cover property (o_fwd_valid && o_fwd_drop);
   cov_inner_kept: cover property (o_fwd_valid && o_fwd_inner_kept);
endmodule
`default_nettype wire

/* hdl/vpi_pkg.sv */
`default_nettype none
package vpi_pkg;
   localparam int NUM_PORTS = 6;
   localparam int NUM_ENTRIES = 8;
   localparam int VID_W = 12;
   localparam int TPID_W = 16;
   localparam logic [VID_W-1:0] DEFAULT_VID = 12'h001;
   localparam logic [VID_W-1:0] UNUSED_VID = 12'h000;
   localparam logic [TPID_W-1:0] CTAG_TPID = 16'h8100;
   localparam logic [TPID_W-1:0] STAG_TPID_RESET = 16'h88A8;
   localparam logic ISOLATION_RESET = 1'b0;
   localparam logic AWARE_RESET = 1'b0;
   localparam logic PVLAN_MEMBER_RESET = 1'b1;
endpackage
`default_nettype wire

/* hdl/vpi_tbl_if.sv */
`default_nettype none
interface vpi_tbl_if #(
   parameter int PORTS = vpi_pkg::NUM_PORTS,
   parameter int ENTRIES = vpi_pkg::NUM_ENTRIES
);
   logic [vpi_pkg::VID_W-1:0] lookup_vid;
   logic wr_en;
   logic [$clog2(ENTRIES)-1:0] wr_index;
   logic [vpi_pkg::VID_W-1:0] wr_vid;
   logic [PORTS-1:0] wr_member;
   logic [PORTS-1:0] wr_untag;
   logic hit [ENTRIES];
   logic [PORTS-1:0] member [ENTRIES];
   logic [PORTS-1:0] untag [ENTRIES];
   modport table_side (
      input lookup_vid, wr_en, wr_index, wr_vid, wr_member, wr_untag,
      output hit, member, untag
   );
   modport lookup_side (
      output lookup_vid, wr_en, wr_index, wr_vid, wr_member, wr_untag,
      input hit, member, untag
   );
endinterface
`default_nettype wire

/* hdl/vpi_vlan_entry.sv */
`default_nettype none
// One VLAN table row: its VLAN ID, member ports and untagged member ports.
module vpi_vlan_entry #(
   parameter int INDEX = 0,
   parameter int PORTS = vpi_pkg::NUM_PORTS,
   parameter int ENTRIES = vpi_pkg::NUM_ENTRIES
) (
   input wire logic i_clock,    // Core clock.
   input wire logic i_reset,    // Synchronous reset, active high.
   vpi_tbl_if.table_side tbl    // Table write and lookup carrier.
);
   localparam logic [$clog2(ENTRIES)-1:0] MY_INDEX = ($clog2(ENTRIES))'(INDEX);
   logic [vpi_pkg::VID_W-1:0] vid_q;
   logic [PORTS-1:0] member_q;
   logic [PORTS-1:0] untag_q;

   // Row 0 comes up as the default VLAN with every port an untagged member.
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         vid_q <= (INDEX == 0) ? vpi_pkg::DEFAULT_VID : vpi_pkg::UNUSED_VID;
         member_q <= (INDEX == 0) ? {PORTS{1'b1}} : {PORTS{1'b0}};
         untag_q <= (INDEX == 0) ? {PORTS{1'b1}} : {PORTS{1'b0}};
      end else if (tbl.wr_en && tbl.wr_index == MY_INDEX) begin
         vid_q <= tbl.wr_vid;
         member_q <= tbl.wr_member;
         untag_q <= tbl.wr_untag;
      end
   end

   assign tbl.hit[INDEX] = (vid_q == tbl.lookup_vid) && (member_q != '0);
   assign tbl.member[INDEX] = member_q;
   assign tbl.untag[INDEX] = untag_q;
endmodule
`default_nettype wire

/* tb/vpi_station.sv */
`default_nettype none
// Stands in for the attached end stations: one frame header per call.
module vpi_station (
   input wire logic i_clock,                   // Core clock.
   output logic o_valid,                       // Header present.
   output logic [2:0] o_port,                  // Ingress port.
   output logic [vpi_pkg::TPID_W-1:0] o_tpid,  // EtherType after source.
   output logic [vpi_pkg::VID_W-1:0] o_vid     // Tag VLAN ID.
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_valid, o_port, o_tpid, o_vid} = 32'h0;
   task automatic send(input logic [2:0] p, input logic [15:0] t, input logic [11:0] v);
      @(posedge i_clock);
      o_valid <= 1'b1;
      {o_port, o_tpid, o_vid} <= {p, t, v};
   endtask
   // Released lines show the inverse of the last value, then the pipeline drains.
   task automatic idle();
      @(posedge i_clock);
      o_valid <= 1'b0;
      {o_port, o_tpid, o_vid} <= ~{o_port, o_tpid, o_vid};
      repeat (4) @(posedge i_clock);
   endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {time t; logic [2:0] port; logic [11:0] vid; logic [5:0] mask, untag, tag;
      logic inner, iso, drop;} vpi_exp_s;
   // Starts low so that no falling edge is seen at time zero.
   logic i_clock = 1'b0;
   logic i_reset, o_fwd_valid, o_fwd_inner_kept, o_fwd_src_isolated, o_fwd_drop;
   logic i_frame_valid;
   logic [2:0] i_frame_port, i_port_default_vlan_id_port, i_vlan_index, o_fwd_port;
   logic [15:0] i_frame_tpid, i_stag_value, o_stag_tpid, m_stag;
   logic [11:0] i_frame_vid, i_port_default_vlan_id_value, i_vlan_vid, o_fwd_vid;
   logic [5:0] i_isolation_mask, i_pvlan_mask, i_aware_mask, i_custom_sport_mask, wr;
   logic [5:0] i_vlan_member, i_vlan_untag, o_fwd_mask, o_fwd_untag_mask, o_fwd_tag_mask;
   logic [5:0] o_isolation_mask, m_iso, m_pvlan, m_aware;
   logic [11:0] m_port_default_vlan_id [6];
   logic [11:0] m_vid [8];
   logic [5:0] m_mem [8];
   logic [5:0] m_unt [8];
   vpi_exp_s expq [$];
   vpi_exp_s got;
   int miscompares, num_checks;
   vpi_station vpi_station_i (.i_clock, .o_valid(i_frame_valid), .o_port(i_frame_port),
      .o_tpid(i_frame_tpid), .o_vid(i_frame_vid));
   vpi_forward #(.PORTS(6), .ENTRIES(8)) vpi_forward_i (.i_clock, .i_reset, .i_frame_valid,
      .i_frame_port, .i_frame_tpid, .i_frame_vid, .i_isolation_wr(wr[0]), .i_isolation_mask,
      .i_pvlan_wr(wr[1]), .i_pvlan_mask, .i_aware_wr(wr[2]), .i_aware_mask,
      .i_custom_sport_mask, .i_stag_wr(wr[3]), .i_stag_value, .i_port_default_vlan_id_wr(wr[4]), .i_port_default_vlan_id_port,
      .i_port_default_vlan_id_value, .i_vlan_wr(wr[5]), .i_vlan_index, .i_vlan_vid, .i_vlan_member,
      .i_vlan_untag, .o_fwd_valid, .o_fwd_port, .o_fwd_vid, .o_fwd_mask, .o_fwd_untag_mask,
      .o_fwd_tag_mask, .o_fwd_inner_kept, .o_fwd_src_isolated, .o_fwd_drop, .o_isolation_mask,
      .o_stag_tpid);
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic strobe(input int k);
      @(posedge i_clock);
      wr[k] <= 1'b1;
      @(posedge i_clock);
      wr <= 6'h00;
   endtask
   task automatic reset_all();
      i_reset <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      {m_iso, m_pvlan, m_aware, m_stag} = {6'h00, 6'h3F, 6'h00, 16'h88A8};
      for (int i = 0; i < 8; i++) begin
         m_port_default_vlan_id[i % 6] = 12'h001;
         m_vid[i] = 12'(i == 0);
         m_mem[i] = (i == 0) ? 6'h3F : 6'h00;
         m_unt[i] = m_mem[i];
      end
   endtask
   task automatic row(input logic [2:0] k, input logic [11:0] v, input logic [5:0] m, u);
      {i_vlan_index, i_vlan_vid, i_vlan_member, i_vlan_untag} <= {k, v, m, u};
      {m_vid[k], m_mem[k], m_unt[k]} = {v, m, u};
      strobe(5);
   endtask
   // Sends one header and notes the result expected from the mirrored settings.
   task automatic frame(input logic [2:0] p, input logic [15:0] t, input logic [11:0] v);
      vpi_exp_s e;
      logic tg;
      logic [5:0] mem, unt;
      vpi_station_i.send(p, t, v);
      tg = t == 16'h8100 || (i_custom_sport_mask[p] && t == m_stag);
      e.t = $time;
      e.port = p;
      e.vid = (m_aware[p] && tg) ? v : m_port_default_vlan_id[p];
      e.inner = !m_aware[p] && tg;
      e.iso = m_iso[p];
      {mem, unt} = 12'h000;
      for (int i = 7; i >= 0; i--) begin
         if (m_vid[i] == e.vid && m_mem[i] != 6'h00)
            {mem, unt} = {m_mem[i], m_unt[i]};
      end
      e.mask = mem & m_pvlan & (e.iso ? ~m_iso : 6'h3F) & ~(6'h01 << p);
      if (!m_pvlan[p])
         e.mask = 6'h00;
      e.untag = e.mask & unt;
      e.tag = e.mask & ~unt;
      // Dropped only when no row matches or the ingress port is outside the private VLAN.
      e.drop = mem == 6'h00 || !m_pvlan[p];
      expq.push_back(e);
   endtask
   ////////////////////////////////////////////////////////////
   always @(negedge i_clock) begin
      if (o_fwd_valid !== 1'b0 && expq.size() == 0) begin
         check(o_fwd_valid, 1'b0);
      end else if (o_fwd_valid !== 1'b0) begin
         got = expq.pop_front();
         check(32'($time - got.t), 32'd20);
         check(o_fwd_port, got.port);
         check(o_fwd_vid, got.vid);
         check(o_fwd_mask, got.mask);
         check(o_fwd_untag_mask, got.untag);
         check(o_fwd_tag_mask, got.tag);
         check(o_fwd_inner_kept, got.inner);
         check(o_fwd_src_isolated, got.iso);
         check(o_fwd_drop, got.drop);
      end
   end
   initial begin
      #100000;
      miscompares++;
      results();
   end
   initial begin
      logic [15:0] t;
      i_reset = 1'b1;
      wr = 6'h00;
      {i_isolation_mask, i_pvlan_mask, i_aware_mask, i_custom_sport_mask} = 24'h000000;
      {i_stag_value, i_port_default_vlan_id_port, i_port_default_vlan_id_value, i_vlan_index, i_vlan_vid} = 46'h0;
      {i_vlan_member, i_vlan_untag} = 12'h000;
      void'($urandom(32'hA5B8));
      reset_all();
      @(negedge i_clock);
      check(o_isolation_mask, 6'h00);
      check(o_stag_tpid, 16'h88A8);
      frame(3'h3, 16'h0800, 12'h005);
      frame(3'h5, 16'h8100, 12'h001);
      vpi_station_i.idle();
      row(3'h1, 12'h002, 6'h07, 6'h03);
      row(3'h2, 12'h003, 6'h38, 6'h18);
      {i_port_default_vlan_id_port, i_port_default_vlan_id_value} <= {3'h0, 12'h002};
      m_port_default_vlan_id[0] = 12'h002;
      strobe(4);
      i_aware_mask <= 6'h3E;
      m_aware = 6'h3E;
      strobe(2);
      i_custom_sport_mask <= 6'h10;
      frame(3'h0, 16'h0800, 12'h000);
      frame(3'h2, 16'h8100, 12'h002);
      frame(3'h0, 16'h8100, 12'h003);
      frame(3'h3, 16'h8100, 12'h00F);
      frame(3'h4, 16'h88A8, 12'h003);
      frame(3'h5, 16'h88A8, 12'h003);
      vpi_station_i.idle();
      i_stag_value <= 16'h9100;
      m_stag = 16'h9100;
      strobe(3);
      i_isolation_mask <= 6'h06;
      m_iso = 6'h06;
      strobe(0);
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      check(o_stag_tpid, 16'h9100);
      check(o_isolation_mask, 6'h06);
      frame(3'h4, 16'h9100, 12'h002);
      frame(3'h1, 16'h0800, 12'h000);
      frame(3'h0, 16'h8100, 12'h000);
      frame(3'h2, 16'h8100, 12'h002);
      vpi_station_i.idle();
      i_pvlan_mask <= 6'h3B;
      m_pvlan = 6'h3B;
      strobe(1);
      frame(3'h2, 16'h0800, 12'h000);
      frame(3'h0, 16'h0800, 12'h000);
      vpi_station_i.idle();
      for (int g = 0; g < 3; g++) begin
         i_isolation_mask <= 6'($urandom);
         i_aware_mask <= 6'($urandom);
         i_custom_sport_mask <= 6'($urandom);
         strobe(0);
         strobe(2);
         {m_iso, m_aware} = {i_isolation_mask, i_aware_mask};
         for (int n = 0; n < 12; n++) begin
            t = ($urandom_range(2) == 0) ? 16'h8100 : $urandom_range(1) ? m_stag : 16'h0800;
            frame(3'($urandom_range(5)), t, 12'($urandom_range(4)));
         end
         vpi_station_i.idle();
      end
      reset_all();
      @(negedge i_clock);
      check(o_isolation_mask, 6'h00);
      frame(3'h1, 16'h0800, 12'h000);
      vpi_station_i.idle();
      check(expq.size(), 0);
      results();
   end
endmodule
`default_nettype wire
